// File: rtl/odsc_port.v
// Serial command port of an eight channel 8-bit converter / I/O expander.
// Assumes clk at 200 MHz, synchronous active high rst, and all serial
// and pin inputs asynchronous to clk; they are synchronised here.
//
// Behaviour
// (RULE1) Command is 12 bits, MSB first, select low
// (RULE2) Sample data on each serial clock rise
// (RULE3) Word acts at select rise after twelve bits
// (RULE4) Data byte is unsigned code, default zero
// (RULE5) Codes 0 down, 1-8 channels, 10-11 ignored
// (RULE6) Code 9 releases power down, data ignored
// (RULE7) Code 12 writes per pin function select
// (RULE8) Host sets direction with each function choice
// (RULE9) Code 15 writes pin direction register
// (RULE10) Host sends release, function, direction after reset
// (RULE11) Host uses external reset if select glitched
// (RULE12) Capture pins at select fall after 14
// (RULE13) Shift captured byte out from fourth fall
// (RULE14) Ignore falls before first rise in frame
// (RULE15) Code 13 drives data onto pins after rise
// (RULE16) Channel code updates after select rise only
// (RULE17) Output echoes old shift contents otherwise
// (RULE18) Only resets clear shift register, not select
// (RULE19) After reset all pins are high impedance
// (RULE20) Power down turns converter pins into I/O
// (RULE21) External reset input is active low
// (RULE22) Codes, function and direction held until changed
`timescale 1ns/1ps
`include "odsc_map.vh"

module odsc_port (
	input  wire        clk,
	input  wire        rst,
	input  wire        chip_select_n,
	input  wire        serial_clk,
	input  wire        serial_data_in,
	input  wire        external_reset_n,
	input  wire [7:0]  channel_pins_in,
	input  wire        hold_updates,
	output wire        serial_data_out,
	output wire [7:0]  channel_pins_out,
	output wire [7:0]  channel_pins_oe_n,
	output wire [63:0] dac_codes,
	output wire [7:0]  dac_enable,
	output wire        powered_up,
	output wire        frame_dropped
);

	// ==========================================================
	// Input synchronisation
	wire [11:0] sync_bus;   // Second stage outputs

	odsc_sync #(
		.WIDTH (12),
		.INIT  (`ODSC_SYNC_INIT)
	) u_sync (
		.clk  (clk),
		.rst  (rst),
		.din  ({channel_pins_in, external_reset_n, serial_data_in,
		        serial_clk, chip_select_n}),
		.dout (sync_bus)
	);

	wire       cs_n_s  = sync_bus[0];     // Select, synchronised
	wire       sclk_s  = sync_bus[1];     // Serial clock, synchronised
	wire       sdi_s   = sync_bus[2];     // Serial data, synchronised
	wire       ext_n_s = sync_bus[3];     // External reset, synchronised
	wire [7:0] pins_s  = sync_bus[11:4];  // Pin levels, synchronised

	// Active low pin or local reset clears everything but the synchroniser and the edge delay stage
	wire core_rst = rst | ~ext_n_s;       // see (RULE21)

	// ==========================================================
	// Edge detection on synchronised link signals
	reg cs_n_d_reg;   // Select, one cycle late
	reg sclk_d_reg;   // Serial clock, one cycle late

	// Delay stage for edge finding
	always @(posedge clk) begin
		if (rst) begin
			cs_n_d_reg <= 1'b1;
			sclk_d_reg <= 1'b0;
		end else begin
			cs_n_d_reg <= cs_n_s;
			sclk_d_reg <= sclk_s;
		end
	end

	wire cs_fall   = cs_n_d_reg & ~cs_n_s;             // Frame opens
	wire cs_rise   = ~cs_n_d_reg & cs_n_s;             // Frame closes
	wire sclk_rise = ~sclk_d_reg & sclk_s & ~cs_n_s;   // Counted only in frame, see (RULE3)
	wire sclk_fall = sclk_d_reg & ~sclk_s & ~cs_n_s;   // Output edges in frame

	// ==========================================================
	// Command shift register and bit counter
	reg  [11:0] shift_reg;      // Received bits, first bit at top
	reg  [11:0] shift_next;
	reg  [3:0]  bit_cnt_reg;    // Bits this frame, stops at twelve
	reg  [3:0]  bit_cnt_next;

	// Next shift state
	always @* begin
		shift_next   = shift_reg;
		bit_cnt_next = cs_fall ? 4'h0 : bit_cnt_reg;
		if (sclk_rise) begin
			// Sample on rise, MSB arrives first, see (RULE2) (RULE1)
			shift_next = {shift_reg[10:0], sdi_s};
			if (bit_cnt_next != `ODSC_FRAME_BITS) begin
				bit_cnt_next = bit_cnt_next + 4'h1;
			end
		end
	end

	// Select high leaves the shift register untouched
	always @(posedge clk) begin
		if (core_rst) begin
			shift_reg   <= `ODSC_SHIFT_RESET;   // see (RULE18)
			bit_cnt_reg <= 4'h0;
		end else begin
			shift_reg   <= shift_next;
			bit_cnt_reg <= bit_cnt_next;
		end
	end

	// ==========================================================
	// Command buffering
	wire        frame_done = cs_rise & (bit_cnt_reg == `ODSC_FRAME_BITS);   // see (RULE3)
	wire        fifo_in_ready;   // Room for a command
	wire        fifo_out_valid;  // Command waiting
	wire [11:0] head_word;       // Oldest command
	wire        cmd_pop = fifo_out_valid & ~hold_updates;   // Apply unless held
	reg         dropped_reg;     // Frame lost to a full buffer

	odsc_fifo #(
		.WIDTH (12),
		.DEPTH (`ODSC_FIFO_DEPTH),
		.AW    (`ODSC_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.rst       (core_rst),
		.in_valid  (frame_done),
		.in_ready  (fifo_in_ready),
		.in_data   (shift_reg),
		.out_valid (fifo_out_valid),
		.out_ready (~hold_updates),
		.out_data  (head_word)
	);

	// Flag a frame that found the buffer full
	always @(posedge clk) begin
		if (core_rst) begin
			dropped_reg <= 1'b0;
		end else begin
			dropped_reg <= frame_done & ~fifo_in_ready;
		end
	end

	wire [3:0] cmd_code = head_word[`ODSC_CMD_MSB:`ODSC_CMD_LSB];     // Field, top bit first
	wire [7:0] cmd_data = head_word[`ODSC_DATA_MSB:`ODSC_DATA_LSB];   // Data, bit 0 is LSB

	// ==========================================================
	// Configuration state
	reg       powered_reg;   // Analog section released
	reg [7:0] func_reg;      // 1 converter, 0 general I/O
	reg [7:0] dir_reg;       // 1 output, 0 high impedance input
	reg [7:0] par_reg;       // Serial to parallel pin data
	reg       ps_armed_reg;  // Parallel to serial pending

	// Apply one buffered command per cycle
	always @(posedge clk) begin
		if (core_rst) begin
			powered_reg  <= 1'b0;                // Power down by default, see (RULE5)
			func_reg     <= `ODSC_FUNC_RESET;
			dir_reg      <= `ODSC_DIR_RESET;     // All inputs, see (RULE19)
			par_reg      <= `ODSC_PAR_RESET;
			ps_armed_reg <= 1'b0;
		end else begin
			// Capture consumes the arm; a new arm below wins
			if (cs_fall) begin
				ps_armed_reg <= 1'b0;
			end
			if (cmd_pop) begin
				case (cmd_code)
					`ODSC_CMD_PWR_DOWN: begin
						powered_reg <= 1'b0;
						// Converter pins fall back to I/O, direction kept
						func_reg    <= `ODSC_FUNC_RESET;   // see (RULE20)
					end
					`ODSC_CMD_PWR_UP: begin
						powered_reg <= 1'b1;           // Data ignored, see (RULE6)
					end
					`ODSC_CMD_FUNC_SEL: begin
						func_reg <= cmd_data;          // see (RULE7)
					end
					`ODSC_CMD_SER_PAR: begin
						par_reg <= cmd_data;           // see (RULE15)
					end
					`ODSC_CMD_PAR_SER: begin
						ps_armed_reg <= 1'b1;          // see (RULE12)
					end
					`ODSC_CMD_DIR_SET: begin
						dir_reg <= cmd_data;           // see (RULE9)
					end
					default: begin
						// Channel codes handled per channel; 10, 11 no effect
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Per channel converter codes
	genvar ch;
	generate
		for (ch = 0; ch < 8; ch = ch + 1) begin : g_chan
			localparam [31:0] CH_SUM  = `ODSC_CMD_CH_FIRST + ch;   // Field value, full width
			localparam [3:0]  CH_CODE = CH_SUM[3:0];                // Field value, cut to field
			reg [7:0] code_reg;   // Held code for this channel
			// Load only from a completed frame, see (RULE16) (RULE22)
			always @(posedge clk) begin
				if (core_rst) begin
					code_reg <= `ODSC_CODE_RESET;   // see (RULE4)
				end else if (cmd_pop && (cmd_code == CH_CODE)) begin
					code_reg <= cmd_data;           // see (RULE5)
				end
			end
			assign dac_codes[8*ch+7:8*ch] = code_reg;
		end
	endgenerate

	// ==========================================================
	// Parallel to serial frame and serial output
	reg       ps_active_reg;   // This frame returns pin data
	reg [7:0] ps_shift_reg;    // Captured byte, top bit next out
	reg       rise_seen_reg;   // A rise has occurred this frame
	reg [3:0] fall_cnt_reg;    // Counted falls this frame
	reg [3:0] fall_cnt_next;
	reg       so_reg;          // Serial output flop

	// Next fall count, saturating
	always @* begin
		fall_cnt_next = fall_cnt_reg;
		if (fall_cnt_reg != `ODSC_FALL_MAX) begin
			fall_cnt_next = fall_cnt_reg + 4'h1;
		end
	end

	// Frame tracking and output shifting
	always @(posedge clk) begin
		if (core_rst) begin
			ps_active_reg <= 1'b0;
			ps_shift_reg  <= 8'h00;
			rise_seen_reg <= 1'b0;
			fall_cnt_reg  <= 4'h0;
			so_reg        <= 1'b0;
		end else if (cs_fall) begin
			// New frame; grab pins if armed
			rise_seen_reg <= sclk_rise;
			fall_cnt_reg  <= 4'h0;
			ps_active_reg <= ps_armed_reg;
			if (ps_armed_reg) begin
				ps_shift_reg <= pins_s;            // see (RULE12)
			end
		end else if (cs_rise) begin
			ps_active_reg <= 1'b0;
		end else begin
			if (sclk_rise) begin
				rise_seen_reg <= 1'b1;
			end
			// Falls before the first rise are not counted
			if (sclk_fall && rise_seen_reg) begin   // see (RULE14)
				fall_cnt_reg <= fall_cnt_next;
				if (ps_active_reg) begin
					// Byte leaves from the fourth counted fall
					if (fall_cnt_next >= `ODSC_PS_FIRST_EDGE) begin   // see (RULE13)
						so_reg       <= ps_shift_reg[7];
						ps_shift_reg <= {ps_shift_reg[6:0], 1'b0};
					end
				end else begin
					// Echo of previous address and data
					so_reg <= shift_reg[11];        // see (RULE17)
				end
			end
		end
	end

	// ==========================================================
	// Pin and converter output flops
	reg [7:0] pins_out_reg;   // Digital pin levels
	reg [7:0] pins_oe_n_reg;  // Low while pin driven digitally
	reg [7:0] dac_en_reg;     // Converter output live

	// Registered pin drive from configuration
	always @(posedge clk) begin
		if (core_rst) begin
			pins_out_reg  <= 8'h00;
			pins_oe_n_reg <= 8'hFF;                 // High impedance, see (RULE19)
			dac_en_reg    <= 8'h00;
		end else begin
			pins_out_reg  <= par_reg;               // see (RULE15)
			pins_oe_n_reg <= ~(dir_reg & ~func_reg);
			dac_en_reg    <= func_reg & {8{powered_reg}};
		end
	end

	assign serial_data_out   = so_reg;
	assign channel_pins_out  = pins_out_reg;
	assign channel_pins_oe_n = pins_oe_n_reg;
	assign dac_enable        = dac_en_reg;
	assign powered_up        = powered_reg;
	assign frame_dropped     = dropped_reg;

endmodule // odsc_port

// File: rtl/odsc_map.vh
// Constants shared by the serial command port and its helpers.
// Assumes inclusion by bare name from the design files in rtl/.
`ifndef ODSC_MAP_VH
`define ODSC_MAP_VH

// ==========================================================
// Frame layout
`define ODSC_FRAME_BITS     4'hC
`define ODSC_CMD_MSB        11
`define ODSC_CMD_LSB        8
`define ODSC_DATA_MSB       7
`define ODSC_DATA_LSB       0

// ==========================================================
// Command field codes
`define ODSC_CMD_PWR_DOWN   4'h0
`define ODSC_CMD_CH_FIRST   4'h1
`define ODSC_CMD_PWR_UP     4'h9
`define ODSC_CMD_FUNC_SEL   4'hC
`define ODSC_CMD_SER_PAR    4'hD
`define ODSC_CMD_PAR_SER    4'hE
`define ODSC_CMD_DIR_SET    4'hF

// ==========================================================
// Reset values
`define ODSC_CODE_RESET     8'h00
`define ODSC_FUNC_RESET     8'h00
`define ODSC_DIR_RESET      8'h00
`define ODSC_PAR_RESET      8'h00
`define ODSC_SHIFT_RESET    12'h000
// Sync order {pins[7:0], reset_n, data, clock, select_n}
`define ODSC_SYNC_INIT      12'h009

// ==========================================================
// Timing counts in serial clock falling edges
`define ODSC_PS_FIRST_EDGE  4'h4
`define ODSC_FALL_MAX       4'hF

// ==========================================================
// Buffering
`define ODSC_FIFO_DEPTH     8
`define ODSC_FIFO_AW        3

`endif

// File: rtl/odsc_sync.v
// Two flip-flop synchroniser bank for pins arriving from outside clk.
// Assumes a synchronous active high reset on the same clock.
`timescale 1ns/1ps

module odsc_sync #(
	parameter WIDTH = 12,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	input  wire             clk,
	input  wire             rst,
	input  wire [WIDTH-1:0] din,
	output wire [WIDTH-1:0] dout
);

	// ==========================================================
	// Per bit stages
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg meta_reg;   // First stage, read only by second
			reg sync_reg;   // Second stage, safe to use
			// Two stage capture
			always @(posedge clk) begin
				if (rst) begin
					meta_reg <= INIT[i];
					sync_reg <= INIT[i];
				end else begin
					meta_reg <= din[i];
					sync_reg <= meta_reg;
				end
			end
			assign dout[i] = sync_reg;
		end
	endgenerate

endmodule // odsc_sync

// File: rtl/odsc_fifo.v
// Small flip-flop FIFO with valid and ready on both sides.
// Assumes DEPTH is a power of two and AW is its log2.
`timescale 1ns/1ps

module odsc_fifo #(
	parameter WIDTH = 12,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             clk,
	input  wire             rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	localparam [31:0]   DEPTH_W  = DEPTH;  // Depth at integer width
	localparam [AW:0]   FULL_CNT = DEPTH_W[AW:0];  // Entries when full
	localparam [AW-1:0] PTR_ONE  = 1;      // Pointer step
	localparam [AW:0]   CNT_ONE  = 1;      // Count step

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];   // Storage
	reg [AW-1:0]    wr_ptr_reg;            // Next slot to fill
	reg [AW-1:0]    rd_ptr_reg;            // Head slot
	reg [AW:0]      count_reg;             // Occupancy

	wire push = in_valid & in_ready;       // Accepted write
	wire pop  = out_valid & out_ready;     // Accepted read

	assign in_ready  = (count_reg != FULL_CNT);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data  = mem_reg[rd_ptr_reg];

	// ==========================================================
	// Pointers and occupancy
	always @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= in_data;
				wr_ptr_reg          <= wr_ptr_reg + PTR_ONE;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + PTR_ONE;
			end
			// Count moves only when one side acts alone
			if (push && !pop) begin
				count_reg <= count_reg + CNT_ONE;
			end else if (pop && !push) begin
				count_reg <= count_reg - CNT_ONE;
			end
		end
	end

endmodule // odsc_fifo

// File: verification/odsc_port_sva.sv
// Checker on the ports of the serial command port.
// Assumes chip select stays high while queued commands drain.
`timescale 1ns/1ps

module odsc_port_sva (
	input wire        clk,
	input wire        rst,
	input wire        chip_select_n,
	input wire        serial_clk,
	input wire        serial_data_in,
	input wire        external_reset_n,
	input wire [7:0]  channel_pins_in,
	input wire        hold_updates,
	input wire        serial_data_out,
	input wire [7:0]  channel_pins_out,
	input wire [7:0]  channel_pins_oe_n,
	input wire [63:0] dac_codes,
	input wire [7:0]  dac_enable,
	input wire        powered_up,
	input wire        frame_dropped
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ==========================================================
	// Sequences
	sequence s_ext_low;
		!external_reset_n [*5];
	endsequence
	sequence s_held;
		hold_updates [*8];
	endsequence
	// ==========================================================
	// Properties
	property p_rst_vals;
		$fell(rst) |-> channel_pins_oe_n == 8'hFF && dac_codes == 64'h0 && !powered_up;
	endproperty
	property p_ext;
		s_ext_low |=> !powered_up && dac_enable == 8'h00 && channel_pins_oe_n == 8'hFF
			&& dac_codes == 64'h0;
	endproperty
	property p_codes_cs;
		$changed(dac_codes) && external_reset_n && $past(external_reset_n, 6)
			|-> chip_select_n && $past(chip_select_n, 3);
	endproperty
	property p_pwr_cs;
		$rose(powered_up) |-> chip_select_n && $past(chip_select_n, 3);
	endproperty
	property p_pd;
		$fell(powered_up) |=> dac_enable == 8'h00;
	endproperty
	property p_en_pwr;
		dac_enable != 8'h00 |-> $past(powered_up);
	endproperty
	property p_excl;
		(dac_enable & ~channel_pins_oe_n) == 8'h00;
	endproperty
	property p_so_fall;
		$changed(serial_data_out) && external_reset_n && $past(external_reset_n, 6)
			|-> !$past(serial_clk) && $past(serial_clk, 6);
	endproperty
	property p_drop;
		frame_dropped |-> chip_select_n && $past(hold_updates) ##1 !frame_dropped;
	endproperty
	property p_hold;
		s_held |=> $stable(dac_codes) && $stable(powered_up);
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
	a_ext: assert property (p_ext) else $error("external reset ignored");
	a_codes_cs: assert property (p_codes_cs) else $error("code moved in frame");
	a_pwr_cs: assert property (p_pwr_cs) else $error("power up in frame");
	a_pd: assert property (p_pd) else $error("converter live in power down");
	a_en_pwr: assert property (p_en_pwr) else $error("enable without power");
	a_excl: assert property (p_excl) else $error("converter pin driven");
	a_so_fall: assert property (p_so_fall) else $error("output moved off fall");
	a_drop: assert property (p_drop) else $error("bad drop pulse");
	a_hold: assert property (p_hold) else $error("update while held");
endmodule // odsc_port_sva

bind odsc_port odsc_port_sva chk_u (
	.clk(clk), .rst(rst), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
	.serial_data_in(serial_data_in), .external_reset_n(external_reset_n),
	.channel_pins_in(channel_pins_in), .hold_updates(hold_updates),
	.serial_data_out(serial_data_out), .channel_pins_out(channel_pins_out),
	.channel_pins_oe_n(channel_pins_oe_n), .dac_codes(dac_codes), .dac_enable(dac_enable),
	.powered_up(powered_up), .frame_dropped(frame_dropped)
);

// File: verification/odsc_host.sv
// Host controller model driving the three wire command bus.
// Assumes clk of the bench; serial clock period is sixteen clk.
`timescale 1ns/1ps

module odsc_host (
	input  wire clk,
	input  wire serial_data_out,
	output reg  chip_select_n = 1'b1,
	output reg  serial_clk = 1'b0,
	output reg  serial_data_in = 1'b0
);
	reg [1:12] rd; // Output level after each counted fall
	// ==========================================================
	// One frame of nb bits; clock stands still outside it except the rise for pre
	task frame(input [11:0] w, input integer nb, input pre);
		integer i;
		begin
			if (pre) @(posedge clk) serial_clk <= 1'b1; // Stray fall first
			@(posedge clk) chip_select_n <= 1'b0;
			repeat (10) @(posedge clk);
			for (i = 0; i <= nb; i = i + 1) begin
				@(posedge clk) serial_clk <= 1'b0;
				if (i < nb) serial_data_in <= w[11 - i]; // MSB first
				else serial_data_in <= ~serial_data_in;
				repeat (7) @(posedge clk);
				if (i > 0) rd[i] = serial_data_out;
				if (i < nb) serial_clk <= 1'b1;
				repeat (8) @(posedge clk);
			end
			chip_select_n <= 1'b1; // Word acts here
			repeat (12) @(posedge clk);
		end
	endtask
endmodule // odsc_host

// File: verification/testbench.sv
// Self-checking bench for the serial command port.
// Assumes the host model on the serial side and pins modelled here.
`timescale 1ns/1ps

module testbench;
	reg         clk = 1'b0;
	reg         rst = 1'b1;
	reg         external_reset_n = 1'b1;
	reg         hold_updates = 1'b0;
	reg  [7:0]  pin_drive = 8'h00; // Level on pins nobody drives
	reg  [31:0] seed = 32'h1A70;
	reg  [7:0]  func_exp, dir_exp, par_exp, v, keep;
	reg  [63:0] code_exp;
	integer     n_errors = 0;
	integer     total_checks = 0;
	integer     drops = 0;
	integer     i;
	wire        cs_n, sclk, sdi, so, powered_up, frame_dropped;
	wire [7:0]  pins_out, oe_n, dac_en, pins_in;
	wire [63:0] codes;
	// Wire level of each channel pin
	assign pins_in = (~oe_n & pins_out) | (oe_n & pin_drive);
	always #2.5 clk = ~clk;
	always @(posedge clk) if (frame_dropped === 1'b1) drops <= drops + 1;
	odsc_host host_u (.clk(clk), .serial_data_out(so), .chip_select_n(cs_n),
		.serial_clk(sclk), .serial_data_in(sdi));
	odsc_port dut_u (.clk(clk), .rst(rst), .chip_select_n(cs_n), .serial_clk(sclk),
		.serial_data_in(sdi), .external_reset_n(external_reset_n), .channel_pins_in(pins_in),
		.hold_updates(hold_updates), .serial_data_out(so), .channel_pins_out(pins_out),
		.channel_pins_oe_n(oe_n), .dac_codes(codes), .dac_enable(dac_en),
		.powered_up(powered_up), .frame_dropped(frame_dropped));
	// ==========================================================
	// Helpers
	function [7:0] rnd;
		begin
			seed = seed ^ (seed << 13);
			seed = seed ^ (seed >> 17);
			seed = seed ^ (seed << 5);
			rnd = seed[7:0];
		end
	endfunction
	function [7:0] pin_lvl;
		pin_lvl = (dir_exp & ~func_exp & par_exp) | (~(dir_exp & ~func_exp) & pin_drive);
	endfunction
	task chk(input string name, input [63:0] exp, input [63:0] got);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("Error %s expected %h seen %h", name, exp, got);
			end
		end
	endtask
	task chk_cfg(input p);
		begin
			chk("powered_up", {63'h0, p}, {63'h0, powered_up});
			chk("dac_enable", {56'h0, p ? func_exp : 8'h00}, {56'h0, dac_en});
			chk("pins_oe_n", {56'h0, ~(dir_exp & ~func_exp)}, {56'h0, oe_n});
			chk("dac_codes", code_exp, codes);
		end
	endtask
	task cmd(input [3:0] c, input [7:0] d);
		begin
			host_u.frame({c, d}, 12, 1'b0);
			repeat (20) @(posedge clk);
		end
	endtask
	task conclude;
		begin
			$display("checks %0d errors %0d", total_checks, n_errors);
			if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	// ==========================================================
	// Watchdog
	initial begin
		#300000;
		n_errors = n_errors + 1;
		conclude;
	end
	// ==========================================================
	// Main sequence
	initial begin
		func_exp = 8'h00;
		dir_exp = 8'h00;
		code_exp = 64'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		chk_cfg(1'b0);
		cmd(4'h9, rnd()); // Release first
		func_exp = rnd();
		dir_exp = func_exp | rnd();
		cmd(4'hC, func_exp);
		cmd(4'hF, dir_exp);
		chk_cfg(1'b1);
		for (i = 1; i <= 8; i = i + 1) begin
			v = (i == 8) ? 8'hFF : rnd();
			cmd(i[3:0], v);
			code_exp[8 * i - 8 +: 8] = v;
		end
		cmd(4'hA, rnd());
		v = rnd();
		cmd(4'hB, v);
		keep = rnd();
		host_u.frame({4'h1, keep}, 8, 1'b0); // Short frame
		repeat (20) @(posedge clk);
		chk_cfg(1'b1);
		par_exp = rnd();
		cmd(4'hD, par_exp); // Full frame; echoes short frame bits
		chk("so_echo", {53'h0, v[2:0], 4'h1, keep[7:4]}, {53'h0, host_u.rd[1:11]});
		chk("pins_out", {56'h0, par_exp}, {56'h0, pins_out});
		@(posedge clk) pin_drive <= rnd();
		cmd(4'hE, 8'h00);
		host_u.frame(12'hA00, 12, 1'b1);
		chk("p2s_byte", {56'h0, pin_lvl()}, {56'h0, host_u.rd[4:11]});
		@(posedge clk) hold_updates <= 1'b1;
		for (i = 0; i < 9; i = i + 1) begin
			v = rnd();
			host_u.frame({4'h1, v}, 12, 1'b0);
			if (i == 7) keep = v;
		end
		chk("held_codes", code_exp, codes);
		chk("drops", 64'h1, drops);
		@(posedge clk) hold_updates <= 1'b0;
		repeat (60) @(posedge clk);
		code_exp[7:0] = keep;
		chk_cfg(1'b1);
		cmd(4'h0, rnd());
		func_exp = 8'h00;
		chk_cfg(1'b0);
		@(posedge clk) external_reset_n <= 1'b0; // Select held high
		repeat (6) @(posedge clk);
		external_reset_n <= 1'b1;
		repeat (6) @(posedge clk);
		dir_exp = 8'h00;
		code_exp = 64'h0;
		chk_cfg(1'b0);
		conclude;
	end
endmodule // testbench
